//--- rsq_pkg.sv
package rsq_pkg;

  // Serial frame layout: one direction bit, register address, data byte
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic RW_READ = 1'b1;

  // Register addresses on the serial port
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h70;
  localparam logic [6:0] ADDR_PSAVE_CTL = 7'h71;
  localparam logic [6:0] ADDR_CAL_CTL = 7'h72;
  localparam logic [6:0] ADDR_STATUS = 7'h73;

  // Field positions
  localparam int PSAVE_REL_BIT = 0;
  localparam int CAL_GAIN_BIT = 0;
  localparam int CAL_PHASE_BIT = 1;
  localparam int CAL_CARRIER_BIT = 2;

  // Values after reset
  localparam logic SOFT_RESET_RST = 1'b0;
  localparam logic PSAVE_REL_RST = 1'b0;
  localparam logic [2:0] CAL_CTL_RST = 3'h0;

  // Wait after power-saving release before conversion is trusted
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int PSWT_MS = 30;
  localparam int PSWT_CYCLES = PSWT_MS * CLK_FREQ_KHZ;
  localparam int PSWT_CNT_W = 23;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_PSAVE = 2'b01,
    ST_SETTLE = 2'b10,
    ST_RUN = 2'b11
  } seq_state_t;

endpackage

//--- spi_frame_if.sv
`timescale 1ns/1ps
interface spi_frame_if;
  logic frame_done;
  logic is_write;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (output frame_done, output is_write, output addr, output wdata, input rdata);
  modport regs (input frame_done, input is_write, input addr, input wdata, output rdata);
endinterface

//--- spi_frame_slave.sv
`timescale 1ns/1ps
module spi_frame_slave (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic cs_n,
  output logic sdo,
  output logic sdo_oe,
  spi_frame_if.slave frm
);

  logic sclk_s1, sclk_s2, sclk_d;
  logic sdi_s1, sdi_s2;
  logic cs_n_s1, cs_n_s2, cs_n_d;
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] out_reg;
  logic rd_reg;
  logic done_reg, wr_reg;
  logic [6:0] addr_reg;
  logic [7:0] wdata_reg;
  wire sclk_rise = sclk_s2 & ~sclk_d;
  wire sclk_fall = ~sclk_s2 & sclk_d;
  wire cs_act = ~cs_n_s2;
  wire cs_end = cs_n_s2 & ~cs_n_d;
  wire [4:0] bit_full = 5'(rsq_pkg::FRAME_BITS);
  wire [4:0] bit_hdr = 5'(rsq_pkg::HDR_BITS);

  // Pins cross from the host's timing, two flops each before use
  always_ff @(posedge clk) begin
    if (srst) begin
      {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
      {cs_n_s1, cs_n_s2, cs_n_d} <= 3'h7;
    end else if (ce) begin
      {sclk_s1, sclk_s2, sclk_d} <= {sclk, sclk_s1, sclk_s2};
      {sdi_s1, sdi_s2} <= {sdi, sdi_s1};
      {cs_n_s1, cs_n_s2, cs_n_d} <= {cs_n, cs_n_s1, cs_n_s2};
    end
  end

  // Shift in MSB first on rising edges; count saturates past 16 to flag an overlong frame
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (ce) begin
      if (!cs_act) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[14:0], sdi_s2};
        if (bit_cnt_reg <= bit_full) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  // Read data leaves on falling edges once the header is in
  always_ff @(posedge clk) begin
    if (srst) begin
      out_reg <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else if (ce) begin
      sdo_oe <= cs_act;
      if (!cs_act) begin
        sdo <= 1'b0;
        rd_reg <= 1'b0;
      end else if (sclk_rise && bit_cnt_reg == bit_hdr - 5'h01) begin
        rd_reg <= (shift_reg[6] == rsq_pkg::RW_READ);
        addr_reg <= {shift_reg[5:0], sdi_s2};
      end else if (sclk_fall && rd_reg && bit_cnt_reg == bit_hdr) begin
        sdo <= frm.rdata[7];
        out_reg <= {frm.rdata[6:0], 1'b0};
      end else if (sclk_fall && rd_reg && bit_cnt_reg > bit_hdr && bit_cnt_reg < bit_full) begin
        sdo <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  // Commit only a frame of exactly 16 bits, at chip-select release; others are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      done_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end else if (ce) begin
      done_reg <= cs_end && bit_cnt_reg == bit_full;
      if (cs_end && bit_cnt_reg == bit_full) begin
        wr_reg <= (shift_reg[15] != rsq_pkg::RW_READ);
        wdata_reg <= shift_reg[7:0];
      end
    end
  end

  assign frm.frame_done = done_reg;
  assign frm.is_write = wr_reg;
  assign frm.addr = addr_reg;
  assign frm.wdata = wdata_reg;

  a_frame_len_exact: assert property (@(posedge clk) disable iff (srst || !ce)
    done_reg |-> $past(bit_cnt_reg) == bit_full)
    else $error("frame committed with wrong bit count");

endmodule

//--- resolver_converter_reset_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - After any reset the converter stays in power saving until the host releases it.
// - Supply drop to threshold resets the device until supply recovers.
// - Writing one to the soft reset register puts the device in reset.
// - Writing zero releases soft reset; device then stays in power saving.
// - Gain matching, 90 degree phase and carrier error calibrations are provided.
// - Registers reached by 16-bit MSB-first frames: direction, 7-bit address, data byte.
module resolver_converter_reset_sequencer #(
  parameter int PSWT_CYCLES = rsq_pkg::PSWT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic cs_n,
  output logic sdo,
  output logic sdo_oe,
  output logic core_reset,
  output logic power_save,
  output logic conv_ready,
  output logic gain_cal_en,
  output logic phase_cal_en,
  output logic carrier_cal_en
);

  spi_frame_if frm ();

  spi_frame_slave u_spi (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .sclk(sclk),
    .sdi(sdi),
    .cs_n(cs_n),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .frm(frm.slave)
  );

  logic pin_n_s1, pin_n_s2;
  logic sup_s1, sup_s2;
  logic soft_reset_reg;
  logic psave_rel_reg;
  logic [2:0] cal_ctl_reg;
  rsq_pkg::seq_state_t state_reg, state_next;
  logic [22:0] settle_cnt_reg, settle_cnt_next;
  logic core_reset_reg, power_save_reg, conv_ready_reg;
  logic gain_cal_reg, phase_cal_reg, carrier_cal_reg;

  // Reset pin and supply detector come from outside the clock domain
  always_ff @(posedge clk) begin
    if (srst) begin
      {pin_n_s1, pin_n_s2} <= 2'h0;
      {sup_s1, sup_s2} <= 2'h3;
    end else if (ce) begin
      {pin_n_s1, pin_n_s2} <= {reset_pin_n, pin_n_s1};
      {sup_s1, sup_s2} <= {supply_low, sup_s1};
    end
  end

  // Hardware resets clear everything; soft reset spares its own register so a zero can end it
  wire hw_reset = ~pin_n_s2 | sup_s2;
  wire dev_reset = hw_reset | soft_reset_reg;
  wire wr_ok = frm.frame_done & frm.is_write & ~hw_reset;
  wire wr_soft = wr_ok && frm.addr == rsq_pkg::ADDR_SOFT_RESET;
  wire wr_psave = wr_ok && !soft_reset_reg && frm.addr == rsq_pkg::ADDR_PSAVE_CTL;
  wire wr_cal = wr_ok && !soft_reset_reg && frm.addr == rsq_pkg::ADDR_CAL_CTL;
  wire [22:0] settle_last = 23'(PSWT_CYCLES - 1);

  // Read data for the header address, chosen combinationally for the serial shifter
  function automatic logic [7:0] read_mux(input logic [6:0] a, input logic sr, input logic ps,
                                          input logic [2:0] cal, input logic [1:0] st, input logic rdy);
    case (a)
      rsq_pkg::ADDR_SOFT_RESET: read_mux = {7'h00, sr};
      rsq_pkg::ADDR_PSAVE_CTL: read_mux = {7'h00, ps};
      rsq_pkg::ADDR_CAL_CTL: read_mux = {5'h00, cal};
      rsq_pkg::ADDR_STATUS: read_mux = {5'h00, rdy, st};
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign frm.rdata = read_mux(frm.addr, soft_reset_reg, psave_rel_reg, cal_ctl_reg, state_reg, conv_ready_reg);

  // Soft reset register: one enters reset, zero leaves it
  always_ff @(posedge clk) begin
    if (srst) begin
      soft_reset_reg <= rsq_pkg::SOFT_RESET_RST;
    end else if (ce && hw_reset) begin
      soft_reset_reg <= rsq_pkg::SOFT_RESET_RST;
    end else if (ce && wr_soft) begin
      soft_reset_reg <= frm.wdata[0];
    end
  end

  // Control registers fall back to their reset values for every reset source
  // Device resets wait for the clock enable too, so a frozen block keeps its settings
  always_ff @(posedge clk) begin
    if (srst) begin
      psave_rel_reg <= rsq_pkg::PSAVE_REL_RST;
      cal_ctl_reg <= rsq_pkg::CAL_CTL_RST;
    end else if (ce && dev_reset) begin
      psave_rel_reg <= rsq_pkg::PSAVE_REL_RST;
      cal_ctl_reg <= rsq_pkg::CAL_CTL_RST;
    end else if (ce) begin
      if (wr_psave) begin
        psave_rel_reg <= frm.wdata[rsq_pkg::PSAVE_REL_BIT];
      end
      if (wr_cal) begin
        cal_ctl_reg <= frm.wdata[2:0];
      end
    end
  end

  // Sequencer: reset, power saving, settling wait, running
  always_comb begin
    state_next = state_reg;
    settle_cnt_next = settle_cnt_reg;
    case (state_reg)
      rsq_pkg::ST_RESET: begin
        state_next = rsq_pkg::ST_PSAVE;
      end
      rsq_pkg::ST_PSAVE: begin
        settle_cnt_next = 23'h000000;
        if (psave_rel_reg) begin
          state_next = rsq_pkg::ST_SETTLE;
        end
      end
      rsq_pkg::ST_SETTLE: begin
        if (!psave_rel_reg) begin
          state_next = rsq_pkg::ST_PSAVE;
        end else if (settle_cnt_reg == settle_last) begin
          state_next = rsq_pkg::ST_RUN;
        end else begin
          settle_cnt_next = settle_cnt_reg + 23'h000001;
        end
      end
      rsq_pkg::ST_RUN: begin
        if (!psave_rel_reg) begin
          state_next = rsq_pkg::ST_PSAVE;
        end
      end
      default: begin
        state_next = rsq_pkg::ST_RESET;
      end
    endcase
    if (dev_reset) begin
      state_next = rsq_pkg::ST_RESET;
      settle_cnt_next = 23'h000000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= rsq_pkg::ST_RESET;
      settle_cnt_reg <= 23'h000000;
    end else if (ce) begin
      state_reg <= state_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // Outputs registered, power save and ready from the next state and core reset from dev_reset, so each leaves a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      core_reset_reg <= 1'b1;
      power_save_reg <= 1'b1;
      conv_ready_reg <= 1'b0;
    end else if (ce) begin
      core_reset_reg <= dev_reset;
      power_save_reg <= state_next == rsq_pkg::ST_RESET || state_next == rsq_pkg::ST_PSAVE;
      conv_ready_reg <= state_next == rsq_pkg::ST_RUN;
    end
  end

  // Calibrations only act on a powered, settled converter
  always_ff @(posedge clk) begin
    if (srst) begin
      gain_cal_reg <= 1'b0;
      phase_cal_reg <= 1'b0;
      carrier_cal_reg <= 1'b0;
    end else if (ce) begin
      gain_cal_reg <= cal_ctl_reg[rsq_pkg::CAL_GAIN_BIT] && state_next == rsq_pkg::ST_RUN;
      phase_cal_reg <= cal_ctl_reg[rsq_pkg::CAL_PHASE_BIT] && state_next == rsq_pkg::ST_RUN;
      carrier_cal_reg <= cal_ctl_reg[rsq_pkg::CAL_CARRIER_BIT] && state_next == rsq_pkg::ST_RUN;
    end
  end

  assign core_reset = core_reset_reg;
  assign power_save = power_save_reg;
  assign conv_ready = conv_ready_reg;
  assign gain_cal_en = gain_cal_reg;
  assign phase_cal_en = phase_cal_reg;
  assign carrier_cal_en = carrier_cal_reg;

  // Checks; a low clock enable freezes state, so checks pause with it
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst || !ce);

  a_reset_forces_psave: assert property (dev_reset |=> power_save_reg && core_reset_reg)
    else $error("reset did not force power saving");

  a_psave_needs_write: assert property (power_save_reg && !psave_rel_reg |=> power_save_reg)
    else $error("power saving left without release write");

  a_supply_resets: assert property (sup_s2 |=> core_reset_reg && !conv_ready_reg)
    else $error("supply drop did not reset device");

  a_supply_recover: assert property (core_reset_reg && !dev_reset |=> !core_reset_reg)
    else $error("reset held after all sources released");

  a_soft_set: assert property (wr_soft && frm.wdata[0] |=> soft_reset_reg ##1 core_reset_reg)
    else $error("soft reset write of one ignored");

  a_soft_clear: assert property (wr_soft && soft_reset_reg && !frm.wdata[0] |=>
    !soft_reset_reg ##1 power_save_reg)
    else $error("soft reset release wrong");

  a_cal_follow: assert property (wr_cal && state_reg == rsq_pkg::ST_RUN && !wr_soft
    ##1 state_next == rsq_pkg::ST_RUN |=> gain_cal_reg == $past(frm.wdata[0], 2)
    && phase_cal_reg == $past(frm.wdata[1], 2) && carrier_cal_reg == $past(frm.wdata[2], 2))
    else $error("calibration enables do not follow write");

  a_ready_after_wait: assert property ($rose(conv_ready_reg) |->
    $past(state_reg) == rsq_pkg::ST_SETTLE && $past(settle_cnt_reg) == settle_last)
    else $error("conversion ready before settle wait");

  c_soft_cycle: cover property (wr_soft && frm.wdata[0] ##[1:1000] wr_soft && !frm.wdata[0]);
  c_reach_run: cover property ($rose(conv_ready_reg));
  c_supply_drop: cover property (conv_ready_reg ##1 sup_s2);
  c_cal_on: cover property ($rose(phase_cal_reg));

endmodule

//--- host_spi_model.sv
`timescale 1ns/1ps
// Host side of the serial port: mode 0 master, clock parked low between frames
module host_spi_model (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk,
  output logic sdi,
  output logic cs_n
);
  // High time of the serial clock in system clocks, low time is twice this; a bench may slow it down
  int half = 6;

  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end

  // One frame, MSB first; fewer than 16 bits gives a malformed frame
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      repeat (half) @(posedge clk);
      sdi <= word[i];
      repeat (half) @(posedge clk);
      sclk <= 1'b1;
      // Data byte is taken on rising edges; an undriven line counts as unknown
      if (i < 8) rd[i] = (sdo_oe === 1'b1) ? sdo : 1'bx;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi; // Released line must not keep its last bit
    repeat (half) @(posedge clk);
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  localparam int PSWT_SIM = 20;
  localparam int RESWT_SIM = 250; // Shortened host settling wait, keeps the run brief
  localparam int PWR_LOW = 25000; // 100 us of pin low at power-on
  localparam int PIN_LOW = 88; // 350 ns rounded up to whole cycles
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic reset_pin_n = 1'b0;
  logic supply_low = 1'b0;
  wire logic sclk, sdi, cs_n, sdo, sdo_oe, core_reset, power_save, conv_ready;
  wire logic gain_cal_en, phase_cal_en, carrier_cal_en;
  wire logic [2:0] cal_en = {carrier_cal_en, phase_cal_en, gain_cal_en};
  int num_errors = 0;
  int comparisons = 0;
  int settle_cnt = 0;

  always #2 clk = ~clk;

  resolver_converter_reset_sequencer #(.PSWT_CYCLES(PSWT_SIM)) u_resolver_converter_reset_sequencer (
    .clk(clk), .srst(srst), .ce(ce), .reset_pin_n(reset_pin_n), .supply_low(supply_low),
    .sclk(sclk), .sdi(sdi), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .core_reset(core_reset),
    .power_save(power_save), .conv_ready(conv_ready), .gain_cal_en(gain_cal_en),
    .phase_cal_en(phase_cal_en), .carrier_cal_en(carrier_cal_en));

  host_spi_model u_host_spi_model (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));

  // Cycles spent released but not ready; held once ready so a test can read it
  always @(posedge clk) begin
    if (power_save === 1'b1) settle_cnt <= 0;
    else if (conv_ready !== 1'b1) settle_cnt <= settle_cnt + 1;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic pick(input int which);
    case (which)
      0: pick = core_reset;
      1: pick = power_save;
      default: pick = conv_ready;
    endcase
  endfunction

  // Bounded wait for a status output; running out of cycles ends the run
  task automatic wait_for(input int which, input logic val, input int bound, output int cyc);
    cyc = 0;
    while (pick(which) !== val) begin
      if (cyc == bound) begin
        num_errors++;
        $display("mismatch wait %0d expected %b seen %b", which, val, pick(which));
        conclude();
      end else begin
        @(posedge clk);
        cyc++;
      end
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host_spi_model.xfer({~rsq_pkg::RW_READ, a, d}, 16, q);
    repeat (4) @(posedge clk); // Commit lands a few cycles after select rises
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    u_host_spi_model.xfer({rsq_pkg::RW_READ, a, 8'h00}, 16, q);
  endtask

  // Release power saving and time the settle until ready
  task automatic run_up();
    int c;
    wr(rsq_pkg::ADDR_PSAVE_CTL, 8'h01);
    wait_for(2, 1'b1, PSWT_SIM + 40, c);
    check("settle", {7'h00, settle_cnt >= PSWT_SIM && settle_cnt <= PSWT_SIM + 2}, 8'h01);
  endtask

  task automatic t_power_on();
    int c;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (PWR_LOW) @(posedge clk);
    reset_pin_n <= 1'b1;
    wait_for(0, 1'b0, 10, c);
    repeat (RESWT_SIM) @(posedge clk);
    check("idle", {6'h00, power_save, conv_ready}, 8'h02);
  endtask

  // Calibration asked for early must wait for the run state
  task automatic t_release();
    logic [7:0] q;
    wr(rsq_pkg::ADDR_CAL_CTL, 8'h07);
    check("cal early", {5'h00, cal_en}, 8'h00);
    run_up();
    rd(rsq_pkg::ADDR_STATUS, q);
    check("status run", {5'h00, q[2:0]}, 8'h07);
    check("cal run", {5'h00, cal_en}, 8'h07);
  endtask

  task automatic t_cal();
    logic [7:0] q;
    for (int i = 0; i < 8; i++) begin
      wr(rsq_pkg::ADDR_CAL_CTL, 8'(i));
      check("cal", {5'h00, cal_en}, 8'(i));
    end
    rd(rsq_pkg::ADDR_CAL_CTL, q);
    check("cal read", {5'h00, q[2:0]}, 8'h07);
  endtask

  // Soft reset while running, a release attempt inside it, then leave soft reset
  task automatic t_soft();
    int c;
    logic [7:0] q;
    wr(rsq_pkg::ADDR_SOFT_RESET, 8'h01);
    wait_for(0, 1'b1, 10, c);
    check("soft state", {6'h00, power_save, conv_ready}, 8'h02);
    check("soft cal", {5'h00, cal_en}, 8'h00);
    wr(rsq_pkg::ADDR_PSAVE_CTL, 8'h01);
    wr(rsq_pkg::ADDR_SOFT_RESET, 8'h00);
    wait_for(0, 1'b0, 10, c);
    repeat (50) @(posedge clk);
    check("soft out", {6'h00, power_save, conv_ready}, 8'h02);
    rd(rsq_pkg::ADDR_STATUS, q);
    check("status psave", {6'h00, q[1:0]}, 8'h01);
  endtask

  // A 15-bit frame is dropped; then a slow host completes the release
  task automatic t_short();
    logic [7:0] q;
    u_host_spi_model.xfer({~rsq_pkg::RW_READ, rsq_pkg::ADDR_SOFT_RESET, 8'h01}, 15, q);
    repeat (20) @(posedge clk);
    check("short frame", {7'h00, core_reset}, 8'h00);
    u_host_spi_model.half = 10;
    run_up();
    u_host_spi_model.half = 6;
  endtask

  task automatic t_supply();
    int c;
    supply_low <= 1'b1;
    wait_for(0, 1'b1, 5, c);
    repeat (200) @(posedge clk);
    check("supply hold", {7'h00, core_reset}, 8'h01);
    supply_low <= 1'b0;
    wait_for(0, 1'b0, 8, c);
    repeat (RESWT_SIM) @(posedge clk);
    check("supply psave", {6'h00, power_save, conv_ready}, 8'h02);
  endtask

  // Pin pulse on top of a soft reset: the pin clears it, so no release write is needed
  task automatic t_pin();
    int c;
    wr(rsq_pkg::ADDR_SOFT_RESET, 8'h01);
    wait_for(0, 1'b1, 10, c);
    reset_pin_n <= 1'b0;
    repeat (PIN_LOW) @(posedge clk);
    check("pin hold", {7'h00, core_reset}, 8'h01);
    reset_pin_n <= 1'b1;
    wait_for(0, 1'b0, 10, c);
    check("pin psave", {7'h00, power_save}, 8'h01);
    repeat (RESWT_SIM) @(posedge clk);
    run_up();
  endtask

  // Enable low freezes everything, so a supply drop seen only meanwhile never lands
  task automatic t_freeze();
    ce <= 1'b0;
    supply_low <= 1'b1;
    repeat (20) @(posedge clk);
    check("freeze", {5'h00, core_reset, power_save, conv_ready}, 8'h01);
    supply_low <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    check("thaw", {5'h00, core_reset, power_save, conv_ready}, 8'h01);
  endtask

  initial begin
    t_power_on();
    t_release();
    t_cal();
    t_soft();
    t_short();
    t_supply();
    t_pin();
    t_freeze();
    conclude();
  end
endmodule
